// ==== rtl/gp_timer_pkg.sv ====
// Constants shared by the general-purpose timer and its helpers.
// Assumes a 100 MHz system clock that also serves as the processor clock.
package gp_timer_pkg;
    localparam int ADDR_W = 4;
    localparam int CLK_FREQ_MHZ = 100;
    localparam int FREQ_UNITS_PER_MHZ = 64;
    localparam logic [15:0] PROC_FREQ_UNITS =
        16'(CLK_FREQ_MHZ * FREQ_UNITS_PER_MHZ);
    localparam logic [3:0] OFS_CONTROL = 4'h0;
    localparam logic [3:0] OFS_TERMINAL = 4'h2;
    localparam logic [3:0] OFS_COMMAND = 4'h6;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_LIVE = 4'ha;
    localparam logic [3:0] OFS_PROC_REQ = 4'hc;
    localparam logic [3:0] OFS_PROC_ACT = 4'he;
    localparam int CTL_CONT_BIT = 21;
    localparam int CTL_DIR_BIT = 20;
    localparam int CTL_PRESC_LSB = 16;
    localparam int CTL_REFDIV_LSB = 12;
    localparam int CTL_FSEL_LSB = 8;
    localparam int CTL_SRC_LSB = 0;
    localparam int CMD_STOP_BIT = 4;
    localparam int CMD_START_BIT = 0;
    localparam int STS_RUN_BIT = 0;
    localparam logic [31:0] CONTROL_RESET = 32'h0;
    localparam logic [31:0] TERMINAL_RESET = 32'h0;
    localparam logic [15:0] PROC_REQ_RESET = 16'h0;
    localparam logic [2:0] FSEL_MAX = 3'h3;
    typedef enum logic [3:0] {
        SRC_PROC = 4'b0000,
        SRC_32K = 4'b0001,
        SRC_EXT_MASTER_1 = 4'b0100,
        SRC_EXT_MASTER_2 = 4'b0101,
        SRC_MAIN_AUDIO = 4'b1000,
        SRC_ASYNC_AUDIO = 4'b1001,
        SRC_GPIO_1 = 4'b1100,
        SRC_GPIO_2 = 4'b1101,
        SRC_GPIO_3 = 4'b1110,
        SRC_GPIO_4 = 4'b1111
    } ref_src_t;
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_RATIO = 2'b01,
        CAL_ACTUAL = 2'b10
    } cal_state_t;
endpackage

// ==== rtl/tick_if.sv ====
// Single-cycle tick passed between divider stages of the timer.
// Assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none
interface tick_if;
    logic tick;
    modport drv (output tick);
    modport rcv (input tick);
endinterface
`default_nettype wire

// ==== rtl/ratio_divider.sv ====
// Sequential restoring divider, one quotient bit per clock.
// Assumes the divisor is held steady while busy; a new go restarts it.
`timescale 1ns/1ns
`default_nettype none
module ratio_divider
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Operation
    input wire logic i_go,
    input wire logic [15:0] i_dividend,
    input wire logic [15:0] i_divisor,
    // Result
    output logic o_done,
    output logic [15:0] o_quotient
);
    typedef struct packed {
        logic busy;
        logic done;
        logic [4:0] cnt;
        logic [15:0] rem;
        logic [15:0] quo;
    } div_st_t;
    div_st_t st_r, st_nxt;
    logic [16:0] shifted;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.done = 1'b0;
        shifted = {st_r.rem, st_r.quo[15]};
        if (i_go)
        begin
            st_nxt.busy = 1'b1;
            st_nxt.cnt = 5'h0;
            st_nxt.rem = 16'h0;
            st_nxt.quo = i_dividend;
        end
        else if (st_r.busy)
        begin
            // A zero divisor yields all ones, never a zero ratio.
            if (shifted >= {1'b0, i_divisor})
            begin
                st_nxt.rem = 16'(shifted - {1'b0, i_divisor});
                st_nxt.quo = {st_r.quo[14:0], 1'b1};
            end
            else
            begin
                st_nxt.rem = shifted[15:0];
                st_nxt.quo = {st_r.quo[14:0], 1'b0};
            end
            st_nxt.cnt = st_r.cnt + 5'h1;
            if (st_r.cnt == 5'hf)
            begin
                st_nxt.busy = 1'b0;
                st_nxt.done = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_done = st_r.done;
    assign o_quotient = st_r.quo;
endmodule // ratio_divider
`default_nettype wire

// ==== rtl/pulse_divider.sv ====
// Divides a tick stream by a power of two from 1 to 128.
// Assumes input ticks are single-cycle pulses; output lags by one cycle.
`timescale 1ns/1ns
`default_nettype none
module pulse_divider
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Control
    input wire logic i_clear,
    input wire logic [2:0] i_log2,
    // Ticks
    tick_if.rcv i_in,
    tick_if.drv o_out
);
    typedef struct packed {
        logic [6:0] cnt;
        logic out;
    } pd_st_t;
    pd_st_t st_r, st_nxt;
    logic [7:0] one_hot;
    logic [6:0] limit;

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.out = 1'b0;
        one_hot = 8'h01 << i_log2;
        limit = 7'(one_hot - 8'h01);
        if (i_clear)
            st_nxt.cnt = 7'h0;
        else if (i_in.tick)
        begin
            if (st_r.cnt >= limit)
            begin
                st_nxt.cnt = 7'h0;
                st_nxt.out = 1'b1;
            end
            else
                st_nxt.cnt = st_r.cnt + 7'h1;
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            st_r <= '0;
        else
            st_r <= st_nxt;
    end

    assign o_out.tick = st_r.out;

    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_div_by_one: assert property (
        i_log2 == 3'h0 && i_in.tick && !i_clear |=> o_out.tick)
        else $error("Divide-by-one stage dropped a tick.");
endmodule // pulse_divider
`default_nettype wire

// ==== rtl/gp_timer.sv ====
// General-purpose up/down time-stamp timer with reference selection,
// three divider stages and a processor-clock ratio calculator.
// Assumes all reference inputs are levels synchronous to i_clk, which
// is also the processor clock.
// Functional notes
// - Direction bit 20: 0 counts down, 1 counts up; resets to 0.
// - Prescale bits 18:16 divide the tick by 1 to 128.
// - Reference divider bits 14:12 divide by 1 to 128, bypassed for processor.
// - Processor clock off: reference divider output clocks the event logger.
// - Bits 10:8 pick the derived frequency for audio clock sources.
// - Bits 3:0 select processor, 32 kHz, master, audio or GPIO source.
// - Terminal count is the final value up, the start value down.
// - Writing 1 to command bit 4 stops the timer.
// - Writing 1 to command bit 0 starts, or reloads and restarts.
// - Status bit 0 shows the running flag, resetting to 0.
// - The live count is readable at 0x0a and resets to zero.
// - A 16-bit request in 1/64 MHz units sets the processor reference.
// - The processor reference is an integer division of that clock.
// - The generated processor reference is reported read-only at 0x0e.
// - Bit 21 set restarts automatically; clear runs once and stops.
// - End of count is signalled when the next update would be due.
// - The running flag is driven out for a GPIO pin.
`timescale 1ns/1ns
`default_nettype none
module gp_timer
    import gp_timer_pkg::*;
#(
    parameter logic [15:0] PROC_FREQ = PROC_FREQ_UNITS
)
(
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register port
    input wire logic [ADDR_W-1:0] i_addr,
    input wire logic [31:0] i_wr_data,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [31:0] o_rd_data,
    // Reference clock levels
    input wire logic i_processor_clock_en,
    input wire logic i_clock_32k,
    input wire logic i_ext_master_clock_1,
    input wire logic i_ext_master_clock_2,
    input wire logic i_main_audio_clock,
    input wire logic i_async_audio_clock,
    input wire logic [3:0] i_gpio_in,
    // Frequency codes of the audio clocks, same scale as the select field
    input wire logic [2:0] i_main_audio_rate,
    input wire logic [2:0] i_async_audio_rate,
    // Status outputs
    output logic o_timer_status,
    output logic o_end_of_count,
    output logic o_logger_ref_tick
);
    typedef struct packed {
        logic cont;
        logic dir;
        logic [2:0] presc;
        logic [2:0] refdiv;
        logic [2:0] fsel;
        logic [3:0] src;
        logic [31:0] terminal;
        logic [15:0] proc_req;
        logic [15:0] proc_ratio;
        logic [15:0] proc_act;
        logic [15:0] proc_cnt;
        logic proc_tick;
        cal_state_t cal;
        logic div_go;
        logic [8:0] lvl_prev;
        logic running;
        logic [31:0] count;
        logic eoc;
        logic log_tick;
        logic [31:0] rd_data;
    } timer_st_t;

    localparam timer_st_t ST_RESET = '{
        cont: CONTROL_RESET[CTL_CONT_BIT],
        dir: CONTROL_RESET[CTL_DIR_BIT],
        presc: CONTROL_RESET[CTL_PRESC_LSB +: 3],
        refdiv: CONTROL_RESET[CTL_REFDIV_LSB +: 3],
        fsel: CONTROL_RESET[CTL_FSEL_LSB +: 3],
        src: CONTROL_RESET[CTL_SRC_LSB +: 4],
        terminal: TERMINAL_RESET,
        proc_req: PROC_REQ_RESET,
        proc_ratio: 16'h1,
        proc_act: 16'h0,
        proc_cnt: 16'h0,
        proc_tick: 1'b0,
        cal: CAL_RATIO,
        div_go: 1'b1,
        lvl_prev: 9'h0,
        running: 1'b0,
        count: 32'h0,
        eoc: 1'b0,
        log_tick: 1'b0,
        rd_data: 32'h0
    };

    timer_st_t st_r, st_nxt;
    logic [8:0] lvl;
    logic [8:0] rise;
    logic raw_edge;
    logic [2:0] fsel_log2;
    logic [2:0] ref_log2;
    logic start_cmd;
    logic stop_cmd;
    logic at_end;
    logic [31:0] ctl_word;
    logic div_done;
    logic [15:0] div_q;
    logic [15:0] div_divisor;

    tick_if raw_t ();
    tick_if fsel_t ();
    tick_if ref_t ();
    tick_if cnt_t ();

    assign lvl = {i_gpio_in, i_async_audio_clock, i_main_audio_clock,
                  i_ext_master_clock_2, i_ext_master_clock_1, i_clock_32k};

    // Inputs are synchronous, so a single history flop finds rising edges.
    genvar gi;
    generate
        for (gi = 0; gi < 9; gi++)
        begin : g_edge
            assign rise[gi] = lvl[gi] & ~st_r.lvl_prev[gi];
        end
    endgenerate

    // Reference source selection and derived-frequency ratio.
    always_comb
    begin
        raw_edge = 1'b0;
        fsel_log2 = 3'h0;
        case (st_r.src)
            SRC_PROC: raw_edge = st_r.proc_tick;
            SRC_32K: raw_edge = rise[0];
            SRC_EXT_MASTER_1: raw_edge = rise[1];
            SRC_EXT_MASTER_2: raw_edge = rise[2];
            SRC_MAIN_AUDIO:
            begin
                raw_edge = rise[3];
                if (i_main_audio_rate > st_r.fsel)
                    fsel_log2 = i_main_audio_rate - st_r.fsel;
            end
            SRC_ASYNC_AUDIO:
            begin
                raw_edge = rise[4];
                if (i_async_audio_rate > st_r.fsel)
                    fsel_log2 = i_async_audio_rate - st_r.fsel;
            end
            SRC_GPIO_1: raw_edge = rise[5];
            SRC_GPIO_2: raw_edge = rise[6];
            SRC_GPIO_3: raw_edge = rise[7];
            SRC_GPIO_4: raw_edge = rise[8];
            default: raw_edge = 1'b0;
        endcase
        // The processor reference is already at its final rate.
        ref_log2 = (st_r.src == SRC_PROC) ? 3'h0 : st_r.refdiv;
    end

    assign raw_t.tick = raw_edge;

    pulse_divider u_fsel_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(start_cmd),
        .i_log2(fsel_log2),
        .i_in(raw_t),
        .o_out(fsel_t)
    );

    pulse_divider u_ref_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(start_cmd),
        .i_log2(ref_log2),
        .i_in(fsel_t),
        .o_out(ref_t)
    );

    pulse_divider u_presc_div (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_clear(start_cmd),
        .i_log2(st_r.presc),
        .i_in(ref_t),
        .o_out(cnt_t)
    );

    // One shared divider computes the ratio, then the achieved frequency.
    assign div_divisor = (st_r.cal == CAL_RATIO) ? st_r.proc_req
                                                 : st_r.proc_ratio;

    ratio_divider u_ratio (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_go(st_r.div_go),
        .i_dividend(PROC_FREQ),
        .i_divisor(div_divisor),
        .o_done(div_done),
        .o_quotient(div_q)
    );

    always_comb
    begin
        start_cmd = i_wr && i_addr == OFS_COMMAND
                    && i_wr_data[CMD_START_BIT];
        stop_cmd = i_wr && i_addr == OFS_COMMAND
                   && i_wr_data[CMD_STOP_BIT];
        at_end = st_r.dir ? (st_r.count == st_r.terminal)
                          : (st_r.count == 32'h0);
        ctl_word = 32'h0;
        ctl_word[CTL_CONT_BIT] = st_r.cont;
        ctl_word[CTL_DIR_BIT] = st_r.dir;
        ctl_word[CTL_PRESC_LSB +: 3] = st_r.presc;
        ctl_word[CTL_REFDIV_LSB +: 3] = st_r.refdiv;
        ctl_word[CTL_FSEL_LSB +: 3] = st_r.fsel;
        ctl_word[CTL_SRC_LSB +: 4] = st_r.src;
    end

    always_comb
    begin
        st_nxt = st_r;
        st_nxt.lvl_prev = lvl;
        st_nxt.eoc = 1'b0;
        st_nxt.div_go = 1'b0;
        st_nxt.rd_data = 32'h0;
        st_nxt.log_tick = ref_t.tick && !i_processor_clock_en;

        // Processor reference: one tick every ratio cycles.
        st_nxt.proc_tick = 1'b0;
        if (st_r.proc_cnt + 16'h1 >= st_r.proc_ratio)
        begin
            st_nxt.proc_cnt = 16'h0;
            st_nxt.proc_tick = 1'b1;
        end
        else
            st_nxt.proc_cnt = st_r.proc_cnt + 16'h1;

        // Calibration sequence for the processor reference.
        case (st_r.cal)
            CAL_IDLE: st_nxt.cal = CAL_IDLE;
            CAL_RATIO:
                if (div_done)
                begin
                    st_nxt.proc_ratio = (div_q == 16'h0) ? 16'h1 : div_q;
                    st_nxt.cal = CAL_ACTUAL;
                    st_nxt.div_go = 1'b1;
                end
            CAL_ACTUAL:
                if (div_done)
                begin
                    st_nxt.proc_act = div_q;
                    st_nxt.cal = CAL_IDLE;
                end
            default: st_nxt.cal = CAL_IDLE;
        endcase

        if (i_wr)
        begin
            case (i_addr)
                OFS_CONTROL:
                begin
                    st_nxt.cont = i_wr_data[CTL_CONT_BIT];
                    st_nxt.dir = i_wr_data[CTL_DIR_BIT];
                    st_nxt.presc = i_wr_data[CTL_PRESC_LSB +: 3];
                    st_nxt.refdiv = i_wr_data[CTL_REFDIV_LSB +: 3];
                    st_nxt.fsel = i_wr_data[CTL_FSEL_LSB +: 3];
                    st_nxt.src = i_wr_data[CTL_SRC_LSB +: 4];
                end
                OFS_TERMINAL: st_nxt.terminal = i_wr_data;
                OFS_PROC_REQ:
                begin
                    st_nxt.proc_req = i_wr_data[15:0];
                    st_nxt.cal = CAL_RATIO;
                    st_nxt.div_go = 1'b1;
                end
                default: st_nxt.cal = st_nxt.cal;
            endcase
        end

        // Counter; a stop in the same write as a start wins.
        if (stop_cmd)
            st_nxt.running = 1'b0;
        else if (start_cmd)
        begin
            st_nxt.running = 1'b1;
            st_nxt.count = st_r.dir ? 32'h0 : st_r.terminal;
        end
        else if (st_r.running && cnt_t.tick)
        begin
            if (at_end)
            begin
                st_nxt.eoc = 1'b1;
                if (st_r.cont)
                    st_nxt.count = st_r.dir ? 32'h0 : st_r.terminal;
                else
                    st_nxt.running = 1'b0;
            end
            else if (st_r.dir)
                st_nxt.count = st_r.count + 32'h1;
            else
                st_nxt.count = st_r.count - 32'h1;
        end

        if (i_rd)
        begin
            case (i_addr)
                OFS_CONTROL: st_nxt.rd_data = ctl_word;
                OFS_TERMINAL: st_nxt.rd_data = st_r.terminal;
                OFS_STATUS:
                    st_nxt.rd_data[STS_RUN_BIT] = st_r.running;
                OFS_LIVE: st_nxt.rd_data = st_r.count;
                OFS_PROC_REQ: st_nxt.rd_data = {16'h0, st_r.proc_req};
                OFS_PROC_ACT: st_nxt.rd_data = {16'h0, st_r.proc_act};
                default: st_nxt.rd_data = 32'h0;
            endcase
        end
    end

    always_ff @(posedge i_clk)
    begin
        if (i_rst)
            st_r <= ST_RESET;
        else
            st_r <= st_nxt;
    end

    assign o_rd_data = st_r.rd_data;
    assign o_timer_status = st_r.running;
    assign o_end_of_count = st_r.eoc;
    assign o_logger_ref_tick = st_r.log_tick;

    default clocking dc @(posedge i_clk); endclocking
    default disable iff (i_rst);

    a_start_up_zero: assert property (
        start_cmd && !stop_cmd && st_r.dir
        |=> st_r.running && st_r.count == 32'h0)
        else $error("Up count did not start at zero.");

    a_start_down_load: assert property (
        start_cmd && !stop_cmd && !st_r.dir
        |=> st_r.count == $past(st_r.terminal))
        else $error("Down count did not load the terminal value.");

    a_stop_quiet: assert property (
        stop_cmd |=> !st_r.running && !o_end_of_count)
        else $error("Stop left the timer running or raised an event.");

    a_eoc_on_next: assert property (
        st_r.running && cnt_t.tick && !start_cmd && !stop_cmd
        |=> o_end_of_count == $past(at_end))
        else $error("End of count not tied to the next update.");

    a_single_halts: assert property (
        o_end_of_count && !$past(st_r.cont) && !$past(start_cmd)
        |-> !st_r.running)
        else $error("Single mode kept running after end of count.");

    a_cont_reloads: assert property (
        o_end_of_count && $past(st_r.cont) && !$past(stop_cmd) && !stop_cmd
        |-> st_r.running ##1 st_r.running)
        else $error("Continuous mode stopped at end of count.");

    a_step_up: assert property (
        st_r.running && cnt_t.tick && !at_end && st_r.dir
        && !start_cmd && !stop_cmd
        |=> st_r.count == $past(st_r.count) + 32'h1)
        else $error("Up count did not step by one.");

    a_status_read: assert property (
        i_rd && i_addr == OFS_STATUS
        |=> o_rd_data == {31'h0, $past(st_r.running)})
        else $error("Status read does not show the running flag.");

    a_count_read: assert property (
        i_rd && i_addr == OFS_LIVE |=> o_rd_data == $past(st_r.count))
        else $error("Live count read is wrong.");

    a_logger_tick: assert property (
        ref_t.tick && !i_processor_clock_en |=> o_logger_ref_tick)
        else $error("Logger tick missing while processor clock is off.");

    a_actual_report: assert property (
        st_r.cal == CAL_ACTUAL && div_done && !i_wr
        |=> st_r.proc_act == $past(div_q) && st_r.cal == CAL_IDLE)
        else $error("Achieved frequency not reported.");

    c_single_end: cover property (o_end_of_count && !st_r.running);
    c_cont_end: cover property (o_end_of_count && st_r.running);
    c_restart: cover property (start_cmd && st_r.running);
    c_stop_run: cover property (stop_cmd && st_r.running);
endmodule // gp_timer
`default_nettype wire

// ==== verif/general_purpose_timer_test.sv ====
// Self-checking bench for the general-purpose timer, driven over its
// register port with the reference inputs made here as slow levels.
// Assumes the 100 MHz clock and a synchronous, active-high reset.
`timescale 1ns/1ns
`default_nettype none
module general_purpose_timer_test;
    import gp_timer_pkg::*;

    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [ADDR_W-1:0] i_addr = 4'h0;
    logic [31:0] i_wr_data = 32'h0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [31:0] o_rd_data;
    logic i_processor_clock_en = 1'b0;
    logic o_timer_status;
    logic o_end_of_count;
    logic o_logger_ref_tick;
    logic [3:0] src_r = 4'h0;
    logic lvl_r = 1'b0;
    logic [2:0] rate_r = 3'h0;
    int fsel_shift = 0;
    int fails = 0;
    int num_checks = 0;
    int eoc_cnt = 0;
    int log_cnt = 0;

    // Only the selected reference input moves; all others sit low.
    gp_timer u_gp_timer (
        .i_clk(i_clk), .i_rst(i_rst), .i_addr(i_addr),
        .i_wr_data(i_wr_data), .i_wr(i_wr), .i_rd(i_rd),
        .o_rd_data(o_rd_data),
        .i_processor_clock_en(i_processor_clock_en),
        .i_clock_32k(lvl_r & (src_r == 4'h1)),
        .i_ext_master_clock_1(lvl_r & (src_r == 4'h4)),
        .i_ext_master_clock_2(lvl_r & (src_r == 4'h5)),
        .i_main_audio_clock(lvl_r & (src_r == 4'h8)),
        .i_async_audio_clock(lvl_r & (src_r == 4'h9)),
        .i_gpio_in({4{lvl_r}} & (4'h1 << src_r[1:0]) & {4{src_r[3:2] == 2'h3}}),
        .i_main_audio_rate(rate_r), .i_async_audio_rate(rate_r),
        .o_timer_status(o_timer_status), .o_end_of_count(o_end_of_count),
        .o_logger_ref_tick(o_logger_ref_tick)
    );

    always #5 i_clk = ~i_clk;

    always @(posedge i_clk)
    begin
        if (o_end_of_count === 1'b1) eoc_cnt++;
        if (o_logger_ref_tick === 1'b1) log_cnt++;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                       input string what);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: %s got %h expected %h",
                     $time, what, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge i_clk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wr_data <= d;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd_chk(input logic [3:0] a, input logic [31:0] exp,
                          input string what);
        @(posedge i_clk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        chk(o_rd_data, exp, what);
    endtask

    // One reference edge every eight cycles, well below a third of i_clk.
    // That is 12.5 MHz, so with the processor clock on a divider is needed.
    task automatic edges(input int n);
        repeat (n)
        begin
            @(posedge i_clk);
            lvl_r <= 1'b1;
            repeat (4) @(posedge i_clk);
            lvl_r <= 1'b0;
            repeat (3) @(posedge i_clk);
        end
    endtask

    function automatic logic [31:0] ctl(input bit cont, input bit up,
        input logic [2:0] presc, input logic [2:0] rdiv, input logic [3:0] s);
        return (32'(cont) << CTL_CONT_BIT) | (32'(up) << CTL_DIR_BIT) |
               (32'(presc) << CTL_PRESC_LSB) | (32'(rdiv) << CTL_REFDIV_LSB) |
               (32'(s) << CTL_SRC_LSB);
    endfunction

    task automatic start_timer(input logic [31:0] c, input logic [31:0] t);
        src_r <= c[3:0];
        wr(OFS_CONTROL, c);
        wr(OFS_TERMINAL, t);
        wr(OFS_COMMAND, 32'h1);
        eoc_cnt = 0;
        log_cnt = 0;
    endtask

    // Counts reference edges until the single-shot run signals its end.
    task automatic eoc_run(input logic [31:0] c, input logic [31:0] t,
                           input int exp);
        int n;
        int lexp;
        n = 0;
        lexp = exp >> (c[14:12] + fsel_shift);
        start_timer(c, t);
        while (eoc_cnt == 0 && n < 300)
        begin
            edges(1);
            n++;
        end
        chk(32'(n), 32'(exp), "edges to end");
        chk(32'(eoc_cnt), 32'h1, "single end pulse");
        chk(32'(log_cnt), 32'(lexp), "logger ticks");
        chk({31'h0, o_timer_status}, 32'h0, "status pin");
        rd_chk(OFS_STATUS, 32'h0, "stopped at end");
    endtask

    task automatic reset_values;
        rd_chk(OFS_CONTROL, CONTROL_RESET, "control reset");
        rd_chk(OFS_TERMINAL, TERMINAL_RESET, "terminal reset");
        rd_chk(OFS_STATUS, 32'h0, "status reset");
        rd_chk(OFS_LIVE, 32'h0, "live reset");
        rd_chk(OFS_COMMAND, 32'h0, "command reads zero");
        wr(4'h4, 32'hffff_ffff);
        rd_chk(4'h4, 32'h0, "unmapped reads zero");
        wr(OFS_STATUS, 32'h1);
        rd_chk(OFS_STATUS, 32'h0, "status read only");
    endtask

    task automatic sources_and_dividers;
        eoc_run(ctl(0, 1, 3'h0, 3'h0, 4'h1), 32'h2, 3);
        eoc_run(ctl(0, 0, 3'h1, 3'h0, 4'h4), 32'h3, 8);
        eoc_run(ctl(0, 1, 3'h0, 3'h2, 4'h5), 32'h0, 4);
        eoc_run(ctl(0, 1, 3'h7, 3'h0, 4'h8), 32'h0, 128);
        eoc_run(ctl(0, 0, 3'h0, 3'h1, 4'h9), 32'h0, 2);
        // Async source at rate code 2 with select code 1 halves the edges.
        rate_r <= 3'h2;
        fsel_shift = 1;
        eoc_run(ctl(0, 1, 3'h0, 3'h0, 4'h9) | 32'h100,
                32'h0, 2);
        rate_r <= 3'h0;
        fsel_shift = 0;
        for (int g = 12; g < 16; g++)
            eoc_run(ctl(0, 1, 3'h0, 3'h0, 4'(g)), 32'h1, 2);
    endtask

    task automatic restart_and_stop;
        start_timer(ctl(0, 0, 3'h0, 3'h0, 4'h1), 32'h5);
        rd_chk(OFS_LIVE, 32'h5, "down start value");
        edges(2);
        rd_chk(OFS_LIVE, 32'h3, "down count");
        wr(OFS_COMMAND, 32'h1);
        rd_chk(OFS_LIVE, 32'h5, "reload on restart");
        rd_chk(OFS_STATUS, 32'h1, "running");
        wr(OFS_COMMAND, 32'h10);
        rd_chk(OFS_STATUS, 32'h0, "stopped");
        chk({31'h0, o_timer_status}, 32'h0, "status pin stop");
        edges(8);
        chk(32'(eoc_cnt), 32'h0, "no end after stop");
    endtask

    task automatic continuous_mode;
        start_timer(ctl(1, 1, 3'h0, 3'h0, 4'h1), 32'h1);
        edges(6);
        chk(32'(eoc_cnt), 32'h3, "continuous ends");
        chk({31'h0, o_timer_status}, 32'h1, "still running");
        wr(OFS_COMMAND, 32'h11);
        rd_chk(OFS_STATUS, 32'h0, "stop wins");
    endtask

    task automatic processor_reference;
        i_processor_clock_en <= 1'b1;
        wr(OFS_PROC_REQ, 32'd3000);
        repeat (60) @(posedge i_clk);
        rd_chk(OFS_PROC_REQ, 32'd3000, "request readback");
        rd_chk(OFS_PROC_ACT, 32'(PROC_FREQ_UNITS / 2),
               "actual ref");
        wr(OFS_PROC_ACT, 32'h1);
        rd_chk(OFS_PROC_ACT, 32'(PROC_FREQ_UNITS / 2), "actual ro");
        // A ratio of 2 puts the four ticks two cycles apart; with the three
        // stage pipeline the end lands 10 or 11 cycles after the start.
        start_timer(ctl(0, 1, 3'h0, 3'h0, 4'h0), 32'h3);
        repeat (8) @(posedge i_clk);
        #1;
        chk(32'(eoc_cnt), 32'h0, "processor ref early");
        repeat (8) @(posedge i_clk);
        chk(32'(eoc_cnt), 32'h1, "processor ref end");
        chk({31'h0, o_timer_status}, 32'h0, "processor ref stop");
        start_timer(ctl(0, 1, 3'h0, 3'h1, 4'h1), 32'h7);
        edges(2);
        chk(32'(log_cnt), 32'h0, "no logger tick");
        wr(OFS_COMMAND, 32'h10);
    endtask

    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (4) @(posedge i_clk);
        i_rst <= 1'b0;
        repeat (50) @(posedge i_clk);
        reset_values();
        sources_and_dividers();
        restart_and_stop();
        continuous_mode();
        processor_reference();
        results();
    end

    // The whole sequence needs well under 10,000 cycles.
    initial
    begin
        #400000;
        fails++;
        results();
    end
endmodule // general_purpose_timer_test
`default_nettype wire
